//--- inc/bridge_params.svh
// Register indices, field positions, reset values and response codes of the bridge register bank
`ifndef BRIDGE_PARAMS_SVH
`define BRIDGE_PARAMS_SVH

// Register indices; the byte address is four times the index
`define SEC_STATUS_IDX 6'h1e
`define WIN_BASE_IDX 6'h20
`define WIN_LIMIT_IDX 6'h22

// Reset values
`define SEC_STATUS_RST 16'h02a0
`define WIN_BASE_RST 16'hfff0
`define WIN_LIMIT_RST 16'h0000

// Status field positions
`define ST_PARITY_BIT 15
`define ST_SYSERR_BIT 14
`define ST_MABORT_BIT 13
`define ST_TABORT_RX_BIT 12
`define ST_TABORT_TX_BIT 11
`define ST_TIMING_LSB 9
`define ST_TIMING_MSB 10
`define ST_MPARITY_BIT 8
`define ST_B2B_BIT 7
`define ST_SPEED_BIT 5
`define ST_TIMING_VAL 2'h1

// Window register layout
`define WIN_FIELD_LSB 4
`define WIN_FIELD_MSB 15
`define WIN_LOW_FILL 20'h00000
`define WIN_HIGH_FILL 20'hfffff

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- inc/bridge_pkg.sv
// Types shared by the bridge register bank, its secondary bus model and its bench
package bridge_pkg;

  // Error events reported by the secondary-bus engine, one-cycle pulses
  typedef struct packed {
    logic parity;
    logic master_abort;
    logic target_abort;
  } err_events_t;

  // Processor memory access offered for window decode
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } mem_req_t;

  // Register selected by a bus access
  typedef enum {
    SEL_STATUS,
    SEL_BASE,
    SEL_LIMIT,
    SEL_NONE
  } reg_sel_t;

endpackage

//--- logic/window_compare.sv
// Compares an address against a 1-MB aligned base/limit window
`include "bridge_params.svh"

module window_compare #(
  parameter int ADDR_W = 32,
  parameter int FIELD_W = 12
) (
  input wire logic [FIELD_W-1:0] base_field,
  input wire logic [FIELD_W-1:0] limit_field,
  input wire logic [ADDR_W-1:0] addr,
  output logic hit
);

  logic [ADDR_W-1:0] low_edge;
  logic [ADDR_W-1:0] high_edge;

  assign low_edge = {base_field, `WIN_LOW_FILL};
  assign high_edge = {limit_field, `WIN_HIGH_FILL};
  assign hit = (addr >= low_edge) && (addr <= high_edge);

endmodule

//--- logic/bridge_secondary_status_membase.sv
// Secondary status and memory window base registers of the virtual bridge, on AXI4-Lite
//
// The AXI4-Lite interface to the registers was left to the implementer.
`include "bridge_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Secondary parity error sets status bit 15
// - Unexpected master abort sets status bit 13
// - Received target abort sets status bit 12
// - Bit 14 always reads zero
// - Bit 11 always reads zero
// - Bits 10:9 read constant 01b
// - Bit 8 always reads zero
// - Bit 7 always reads one
// - Bit 5 always reads one
// - Base bits 15:4 hold A[31:20]
// - Base bits 3:0 read zero
// - Base compare treats A[19:0] as zero
// - Forward when base <= address <= limit
// - Limit compare treats A[19:0] as ones
module bridge_secondary_status_membase #(
  parameter int ADDR_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire bridge_pkg::err_events_t err_events,
  input wire bridge_pkg::mem_req_t mem_req,
  output logic fwd_valid,
  output logic fwd_hit
);

  localparam int FIELD_W = `WIN_FIELD_MSB - `WIN_FIELD_LSB + 1;
  localparam logic [15:0] BASE_RST = `WIN_BASE_RST;
  localparam logic [15:0] LIMIT_RST = `WIN_LIMIT_RST;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic awready_q;
  logic wready_q;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic aw_held_d;
  logic w_held_d;
  logic bvalid_d;
  logic rvalid_d;
  bridge_pkg::reg_sel_t wsel;
  bridge_pkg::reg_sel_t rsel;
  logic parity_q;
  logic mabort_q;
  logic tabort_q;
  logic [2:0] clr_bits;
  logic [FIELD_W-1:0] base_q;
  logic [FIELD_W-1:0] limit_q;
  logic [15:0] status_view;
  logic [15:0] base_view;
  logic [15:0] limit_view;
  logic [15:0] read_view;
  logic win_hit;
  logic fwd_valid_q;
  logic fwd_hit_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic bridge_pkg::reg_sel_t decode(input logic [7:0] a);
    bridge_pkg::reg_sel_t s;
    s = bridge_pkg::SEL_NONE;
    if (a[7:2] == `SEC_STATUS_IDX)
    begin
      s = bridge_pkg::SEL_STATUS;
    end
    else if (a[7:2] == `WIN_BASE_IDX)
    begin
      s = bridge_pkg::SEL_BASE;
    end
    else if (a[7:2] == `WIN_LIMIT_IDX)
    begin
      s = bridge_pkg::SEL_LIMIT;
    end
    return s;
  endfunction

  assign wsel = decode(awaddr_q);
  assign rsel = decode(araddr);

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel

  assign aw_take = awvalid && awready_q;
  assign w_take = wvalid && wready_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  assign aw_held_d = do_write ? 1'b0 : (aw_held_q || aw_take);
  assign w_held_d = do_write ? 1'b0 : (w_held_q || w_take);
  // Response stands until the master takes it
  assign bvalid_d = do_write || (bvalid_q && !bready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awready_q <= !aw_held_d && !bvalid_d;
      wready_q <= !w_held_d && !bvalid_d;
      bvalid_q <= bvalid_d;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bresp_q <= `RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        awaddr_q <= awaddr;
      end
      if (w_take)
      begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write)
      begin
        bresp_q <= (wsel == bridge_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky error bits

  // only written ones clear, lane 1 carries them
  always_comb
  begin
    clr_bits = 3'h0;
    if (do_write && wsel == bridge_pkg::SEL_STATUS && wstrb_q[1])
    begin
      clr_bits = {wdata_q[`ST_PARITY_BIT], wdata_q[`ST_MABORT_BIT], wdata_q[`ST_TABORT_RX_BIT]};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      parity_q <= 1'b0;
    end
    else
    begin
      parity_q <= (parity_q && !clr_bits[2]) || err_events.parity;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mabort_q <= 1'b0;
    end
    else
    begin
      mabort_q <= (mabort_q && !clr_bits[1]) || err_events.master_abort;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tabort_q <= 1'b0;
    end
    else
    begin
      tabort_q <= (tabort_q && !clr_bits[0]) || err_events.target_abort;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Window registers

  // base field writable per byte lane
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      base_q <= BASE_RST[`WIN_FIELD_MSB:`WIN_FIELD_LSB];
      limit_q <= LIMIT_RST[`WIN_FIELD_MSB:`WIN_FIELD_LSB];
    end
    else if (do_write)
    begin
      if (wsel == bridge_pkg::SEL_BASE)
      begin
        if (wstrb_q[0])
        begin
          base_q[3:0] <= wdata_q[7:4];
        end
        if (wstrb_q[1])
        begin
          base_q[11:4] <= wdata_q[15:8];
        end
      end
      if (wsel == bridge_pkg::SEL_LIMIT)
      begin
        if (wstrb_q[0])
        begin
          limit_q[3:0] <= wdata_q[7:4];
        end
        if (wstrb_q[1])
        begin
          limit_q[11:4] <= wdata_q[15:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel

  always_comb
  begin
    status_view = 16'h0000;
    status_view[`ST_PARITY_BIT] = parity_q;
    status_view[`ST_SYSERR_BIT] = 1'b0;
    status_view[`ST_MABORT_BIT] = mabort_q;
    status_view[`ST_TABORT_RX_BIT] = tabort_q;
    status_view[`ST_TABORT_TX_BIT] = 1'b0;
    status_view[`ST_TIMING_MSB:`ST_TIMING_LSB] = `ST_TIMING_VAL;
    status_view[`ST_MPARITY_BIT] = 1'b0;
    status_view[`ST_B2B_BIT] = 1'b1;
    status_view[`ST_SPEED_BIT] = 1'b1;
  end

  assign base_view = {base_q, 4'h0};
  assign limit_view = {limit_q, 4'h0};

  always_comb
  begin
    unique case (rsel)
      bridge_pkg::SEL_STATUS: read_view = status_view;
      bridge_pkg::SEL_BASE: read_view = base_view;
      bridge_pkg::SEL_LIMIT: read_view = limit_view;
      bridge_pkg::SEL_NONE: read_view = 16'h0000;
    endcase
  end

  assign ar_take = arvalid && arready_q;

  // Read data stands until the master takes it
  assign rvalid_d = ar_take || (rvalid_q && !rready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end
    else
    begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take)
      begin
        rdata_q <= {16'h0000, read_view};
        rresp_q <= (rsel == bridge_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Window decode

  window_compare #(
    .ADDR_W(ADDR_W),
    .FIELD_W(FIELD_W)
  ) u_cmp (
    .base_field(base_q),
    .limit_field(limit_q),
    .addr(mem_req.addr[ADDR_W-1:0]),
    .hit(win_hit)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fwd_valid_q <= 1'b0;
      fwd_hit_q <= 1'b0;
    end
    else
    begin
      fwd_valid_q <= mem_req.valid;
      fwd_hit_q <= mem_req.valid && win_hit;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign fwd_valid = fwd_valid_q;
  assign fwd_hit = fwd_hit_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence status_read;
    ar_take && rsel == bridge_pkg::SEL_STATUS;
  endsequence

  sequence base_write;
    do_write && wsel == bridge_pkg::SEL_BASE && wstrb_q == 4'hf;
  endsequence

  a_parity_latch: assert property (err_events.parity |=> parity_q ##1 (parity_q || $past(clr_bits[2])))
    else $error("parity fault not latched");

  a_mabort_latch: assert property (err_events.master_abort |=> status_view[13])
    else $error("master abort not latched");

  a_tabort_latch: assert property (err_events.target_abort |=> status_view[`ST_TABORT_RX_BIT])
    else $error("target abort not latched");

  a_syserr_zero: assert property (status_read |=> rdata_q[14] == 1'b0)
    else $error("system error bit not zero");

  a_tabort_tx_zero: assert property (status_read |=> rdata_q[11] == 1'b0 && rvalid_q)
    else $error("signaled target abort not zero");

  a_timing_const: assert property (status_read |=> rdata_q[10:9] == 2'h1)
    else $error("select timing not 01b");

  a_mparity_zero: assert property (status_read |=> rdata_q[8] == 1'b0)
    else $error("master parity bit not zero");

  a_b2b_speed: assert property (status_read |=> rdata_q[7] && rdata_q[5] && rdata_q[6] == 1'b0)
    else $error("capability bits wrong");

  a_speed_one: assert property (status_read |=> rdata_q[5] == 1'b1 && rresp_q == 2'h0)
    else $error("speed capability bit not one");

  a_base_write: assert property (base_write |=> base_q == $past(wdata_q[15:4]) && bvalid_q)
    else $error("base field not written");

  a_base_low_zero: assert property (ar_take && rsel == bridge_pkg::SEL_BASE |=> rdata_q[3:0] == 4'h0)
    else $error("base low nibble not zero");

  a_decode_range: assert property (mem_req.valid |=> fwd_valid_q && fwd_hit_q ==
    ($past(mem_req.addr[31:20]) >= $past(base_q) && $past(mem_req.addr[31:20]) <= $past(limit_q)))
    else $error("window decode wrong");

  a_base_align: assert property (mem_req.valid && mem_req.addr[31:20] == base_q
    && base_q <= limit_q |=> fwd_hit_q)
    else $error("base boundary not 1-MB aligned");

  a_limit_fill: assert property (mem_req.valid && mem_req.addr[31:20] == limit_q
    && base_q <= limit_q |=> fwd_hit_q)
    else $error("limit top not filled with ones");

  a_set_wins: assert property (err_events.parity && clr_bits[2] |=> parity_q)
    else $error("clear beat a same-cycle set");

endmodule

//--- sim/sec_bus_model.sv
// Secondary bus agent model that raises error events on request
module sec_bus_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] fault,
  output bridge_pkg::err_events_t err_events
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // A requested fault shows as an event one cycle later, for each cycle it is asked
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      err_events <= '0;
    else
      err_events <= fault;
  end
endmodule

//--- sim/bridge_secondary_status_membase_bench.sv
// Self-checking bench of the secondary status and window base register bank
module bridge_secondary_status_membase_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fwd_valid, fwd_hit;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  logic [2:0] fault = 3'h0;
  bridge_pkg::mem_req_t mem_req = '0;
  bridge_pkg::err_events_t err_events;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 7200;
  int es, eb, el;
  int pos[3] = '{15, 13, 12};

  always #12.5 aclk = ~aclk;

  bridge_secondary_status_membase dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .err_events(err_events), .mem_req(mem_req),
    .fwd_valid(fwd_valid), .fwd_hit(fwd_hit)
  );

  sec_bus_model partner (.aclk(aclk), .aresetn(aresetn), .fault(fault), .err_events(err_events));

  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      error_cnt++;
    end
  endtask

  task automatic guard(inout int g);
    g++;
    if (g > 200)
    begin
      error_cnt++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ta = 0;
    bit tw = 0;
    bit tb = 0;
    int g = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb)
    begin
      @(posedge aclk);
      guard(g);
      if (ta && tw && bvalid)
      begin
        tb = 1;
        bready <= 1'b0;
        chk(bresp, er);
      end
      if (!ta && awready)
      begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (!tw && wready)
      begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ta = 0;
    bit tr = 0;
    int g = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr)
    begin
      @(posedge aclk);
      guard(g);
      if (!ta && arready)
      begin
        ta = 1;
        arvalid <= 1'b0;
      end
      else if (ta && rvalid)
      begin
        tr = 1;
        rready <= 1'b0;
        chk(rdata, ed);
        chk(rresp, er);
      end
    end
  endtask

  task fire(input logic [2:0] f);
    @(posedge aclk);
    fault <= f;
    @(posedge aclk);
    fault <= 3'h0;
  endtask

  task automatic decchk(input logic [31:0] a);
    logic h;
    h = (a[31:20] >= eb[15:4]) && (a[31:20] <= el[15:4]);
    @(posedge aclk);
    mem_req <= {1'b1, a};
    @(posedge aclk);
    mem_req <= '0;
    #1;
    chk(fwd_valid, 1'b1);
    chk(fwd_hit, h);
  endtask

  task reset_all();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    es = 32'h000002a0;
    eb = 32'h0000fff0;
    el = 32'h00000000;
    rdchk(8'h78, es, 2'h0);
    rdchk(8'h80, eb, 2'h0);
    rdchk(8'h88, el, 2'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_all();
    decchk($random(seed));
    wr(8'h78, 32'hffffffff, 2'h0);
    rdchk(8'h78, es, 2'h0);
    for (int k = 0; k < 3; k++)
    begin
      fire(3'h4 >> k);
      es = es | (1 << pos[k]);
      rdchk(8'h78, es, 2'h0);
      wr(8'h78, 32'h0, 2'h0);
      rdchk(8'h78, es, 2'h0);
    end
    repeat (4)
    begin
      fire(3'h7);
      es = es | 32'h0000b000;
      v = $random(seed);
      wr(8'h78, v, 2'h0);
      es = es & ~(v & 32'h0000b000);
      rdchk(8'h78, es, 2'h0);
    end
    wr(8'h78, 32'h0000ffff, 2'h0);
    es = 32'h000002a0;
    // One-cycle events land on the same edge as the clearing write
    fork
      wr(8'h78, 32'h0000ffff, 2'h0);
      fire(3'h7);
    join
    es = es | 32'h0000b000;
    rdchk(8'h78, es, 2'h0);
    repeat (4)
    begin
      v = $random(seed);
      wr(8'h80, v, 2'h0);
      eb = v & 32'h0000fff0;
      rdchk(8'h80, eb, 2'h0);
      v = (eb + ($random(seed) & 32'h00000ff0)) & 32'h0000ffff;
      wr(8'h88, v, 2'h0);
      el = v & 32'h0000fff0;
      rdchk(8'h88, el, 2'h0);
      decchk({eb[15:4], 20'h00000});
      decchk({eb[15:4], 20'h00000} - 32'h1);
      decchk({el[15:4], 20'hfffff});
      decchk({el[15:4], 20'hfffff} + 32'h1);
      decchk($random(seed));
    end
    wr(8'h84, 32'hffffffff, 2'h2);
    rdchk(8'h84, 32'h0, 2'h2);
    rdchk(8'h80, eb, 2'h0);
    reset_all();
    give_verdict();
  end
endmodule
